// [logic/ssp_map.vh]
/*
 * ssp_map.vh - register indices, field positions, reset values and bus
 * answer codes for the shared serial port pin block.
 * assumes: included by bare name from the design files of this block and from the test bench.
 */
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SSP_IDX_SER0_CTRL_ONE 10'h0_C2
`define SSP_IDX_SER1_CTRL_ONE 10'h0_CA
`define SSP_IDX_SPI_CTRL_ONE 10'h0_D0
`define SSP_IDX_SPI_CTRL_TWO 10'h0_D1
`define SSP_IDX_PORT_DATA 10'h0_D6
`define SSP_IDX_PORT_DIR 10'h0_D7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSP_SER_LOOP_BIT 7
`define SSP_SER_OD_BIT 6
`define SSP_SPI_EN_BIT 6
`define SSP_SPI_OD_BIT 5
`define SSP_SPI_MASTER_BIT 4
`define SSP_PULLUP_BIT 3
`define SSP_RDRIVE_BIT 2
`define SSP_SPC0_BIT 0

// pin positions of the shared functions
`define SSP_PIN_SEL 7
`define SSP_PIN_SCK 6
`define SSP_PIN_MOSI 5
`define SSP_PIN_MISO 4
`define SSP_PIN_TX0 3
`define SSP_PIN_RX0 2
`define SSP_PIN_TX1 1
`define SSP_PIN_RX1 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSP_RST_PORT_DATA 8'h00
`define SSP_RST_PORT_DIR 8'h00
`define SSP_RST_SER_CTRL 8'h00
`define SSP_RST_SPI_CTRL_ONE 8'h00
`define SSP_RST_SPI_CTRL_TWO 8'h08

// ----------------------------------------------------------------
// bus answer codes
// ----------------------------------------------------------------
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10

`endif

// [logic/ssp_pin_sync.v]
/*
 * ssp_pin_sync.v - two-stage synchroniser for the eight port pin levels.
 * assumes: pin levels are asynchronous to clock_i; only the second stage
 * is read by anything outside this module.
 */
`timescale 1ns/1ps

module ssp_pin_sync (
	// clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// raw and synchronised levels
	input wire [7:0] pin_raw_i,
	output wire [7:0] pin_sync_o
);

	// ----------------------------------------------------------------
	// per-bit two flip-flop chain
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
			reg meta_ff; // first stage, read only by stage two
			reg sync_ff; // second stage, safe to use
			always @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
				end else begin
					meta_ff <= pin_raw_i[gi];
					sync_ff <= meta_ff;
				end
			end
			assign pin_sync_o[gi] = sync_ff;
		end
	endgenerate

endmodule

// [logic/ssp_axil_slave.v]
/*
 * ssp_axil_slave.v - AXI4-Lite slave front end: takes address and data in
 * either order, issues one write strobe or one held read address to the register file and
 * returns its answer.
 * assumes: register file answers read data and hit flags combinationally.
 */
`timescale 1ns/1ps
`include "ssp_map.vh"

module ssp_axil_slave (
	// clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// write address and data channels
	input wire [11:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	// write response channel
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// read channels
	input wire [11:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// register file side
	output wire wr_en_o,
	output wire [11:0] wr_addr_o,
	output wire [7:0] wr_data_o,
	output wire wr_lane_o,
	input wire wr_hit_i,
	output wire [11:0] rd_addr_o,
	input wire [7:0] rd_data_i,
	input wire rd_hit_i
);

	reg awready_ff; // free to take a write address
	reg wready_ff; // free to take write data
	reg [11:0] awaddr_ff; // held write address
	reg [7:0] wdata_ff; // held low byte lane
	reg wlane_ff; // low byte lane enabled
	reg bvalid_ff; // write answer pending
	reg [1:0] bresp_ff; // write answer code
	reg arready_ff; // free to take a read address
	reg [11:0] araddr_ff; // held read address
	reg rvalid_ff; // read answer pending
	reg [31:0] rdata_ff; // read answer data
	reg [1:0] rresp_ff; // read answer code

	wire do_wr; // both halves held, no answer out yet
	wire do_rd; // read address held, no answer out yet

	assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
	assign do_rd = !arready_ff && !rvalid_ff;

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	// ready flags drop on capture and rise again once the answer is taken,
	// so at most one write is ever under way
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			awaddr_ff <= 12'h000;
			wdata_ff <= 8'h00;
			wlane_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `SSP_RESP_OKAY;
		end else begin
			if (awready_ff && s_axi_awvalid_i) begin
				awready_ff <= 1'b0;
				awaddr_ff <= s_axi_awaddr_i;
			end
			if (wready_ff && s_axi_wvalid_i) begin
				wready_ff <= 1'b0;
				wdata_ff <= s_axi_wdata_i[7:0];
				wlane_ff <= s_axi_wstrb_i[0];
			end
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit_i ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready_i) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			arready_ff <= 1'b1;
			araddr_ff <= 12'h000;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `SSP_RESP_OKAY;
		end else begin
			if (arready_ff && s_axi_arvalid_i) begin
				arready_ff <= 1'b0;
				araddr_ff <= s_axi_araddr_i;
			end
			if (do_rd) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= {24'h00_0000, rd_hit_i ? rd_data_i : 8'h00};
				rresp_ff <= rd_hit_i ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready_i) begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o = wready_ff;
	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;
	assign wr_en_o = do_wr;
	assign wr_addr_o = awaddr_ff;
	assign wr_data_o = wdata_ff;
	assign wr_lane_o = wlane_ff;
	assign rd_addr_o = araddr_ff;

endmodule

// [logic/ssp_port.v]
/*
 * ssp_port.v - eight-pin general-purpose port shared with two async
 * serial units and one spi unit: data latch, direction, pull-up, drive
 * strength and open-drain control, reached over AXI4-Lite.
 * assumes: the serial and spi units sit outside and exchange pin levels
 * through the unit ports; pads resolve level from out, oe_n and pull-up.
 */
//
// What this block does
// - upper bits serve spi select, clock, mosi, miso
// - lower bits serve both serial units' tx/rx
// - input bit reads the sampled pin level
// - output bit reads the pin driver input
// - writes fill latch; latch drives when output
// - with loop clear, serial tx pin ignores latch writes
// - direction one output, zero input; reset inputs
// - loop clear forces serial rx in, tx out
// - enabled spi input pins are always inputs
// - spi outputs drive only with direction set
// - pull-up bit enables pulls on input pins
// - reduced-drive bit lowers all output drive
// - spi open-drain bit for upper four pins
// - serial open-drain bits per unit pin pair
`timescale 1ns/1ps
`include "ssp_map.vh"

module ssp_port (
	// clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// axi4-lite write address and data
	input wire [11:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// axi4-lite read
	input wire [11:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// pads of the eight shared pins
	input wire [7:0] port_pins_all_i,
	output wire [7:0] port_pins_all_o,
	output wire [7:0] port_pins_all_oe_n_o,
	output wire [7:0] pullup_enable_o,
	output wire [7:0] reduced_drive_select_o,
	// async serial units
	input wire serial_zero_transmit_pin_i,
	input wire serial_one_transmit_pin_i,
	output wire serial_zero_receive_pin_o,
	output wire serial_one_receive_pin_o,
	// spi unit: output levels in, pin levels back
	input wire spi_select_out_i,
	input wire spi_clock_out_i,
	input wire spi_mosi_out_i,
	input wire spi_miso_out_i,
	output wire [3:0] spi_pin_level_o,
	output wire spi_enable_o,
	output wire spi_master_o
);

	// ----------------------------------------------------------------
	// register file state
	// ----------------------------------------------------------------
	reg [7:0] port_pin_data_ff; // output latch
	reg [7:0] port_pin_direction_ff; // one bit per pin, 1 = output
	reg [7:0] serial_zero_ctrl_one_ff; // loop and open-drain of unit zero
	reg [7:0] serial_one_ctrl_one_ff; // loop and open-drain of unit one
	reg [7:0] spi_ctrl_one_ff; // enable, open-drain, master
	reg [7:0] spi_ctrl_two_pull_drive_ff; // pull-up, drive, spc0

	// ----------------------------------------------------------------
	// registered pad and unit outputs
	// ----------------------------------------------------------------
	reg [7:0] pin_out_ff; // value at driver input
	reg [7:0] pin_oe_n_ff; // low while the pad drives
	reg [7:0] pullup_ff; // per-pin pull-up request
	reg [7:0] rdrive_ff; // per-pin reduced drive
	reg [1:0] ser_rx_ff; // rx levels to the serial units
	reg [3:0] spi_lvl_ff; // pin levels to the spi unit
	reg spi_en_ff; // copy of spi enable
	reg spi_mst_ff; // copy of spi master select

	// ----------------------------------------------------------------
	// combinational pin plan
	// ----------------------------------------------------------------
	reg [7:0] nxt_pin_out; // value presented to driver input
	reg [7:0] nxt_drive; // pin actively output
	reg [7:0] force_in; // peripheral claims pin as input
	reg [7:0] force_out; // peripheral claims pin as output
	reg [7:0] use_fn; // driver fed by a peripheral, not the latch
	reg [7:0] fn_val; // peripheral output level per pin
	reg [7:0] spi_out_role; // spi output pins in current mode
	reg [7:0] open_drain; // open-drain select per pin
	reg [7:0] rd_port; // port data as software reads it
	reg [7:0] rd_data; // read answer of the decoded register
	reg rd_hit; // read address maps to a register
	reg wr_hit; // write address maps to a register

	wire [7:0] pin_sync; // synchronised pad levels
	wire wr_en; // write strobe, one cycle
	wire [11:0] wr_addr; // held write byte address
	wire [7:0] wr_data; // held low byte lane
	wire wr_lane; // low byte lane enabled
	wire [11:0] rd_addr; // held read byte address
	wire [9:0] wr_idx; // write register index
	wire [9:0] rd_idx; // read register index
	wire wr_ok; // aligned, mapped, low lane on

	wire loop0; // unit zero loop control
	wire loop1; // unit one loop control
	wire spi_en; // spi unit enabled
	wire spi_mst; // spi in master mode

	assign wr_idx = wr_addr[11:2];
	assign rd_idx = rd_addr[11:2];
	assign wr_ok = wr_en && wr_hit && wr_lane;
	assign loop0 = serial_zero_ctrl_one_ff[`SSP_SER_LOOP_BIT];
	assign loop1 = serial_one_ctrl_one_ff[`SSP_SER_LOOP_BIT];
	assign spi_en = spi_ctrl_one_ff[`SSP_SPI_EN_BIT];
	assign spi_mst = spi_ctrl_one_ff[`SSP_SPI_MASTER_BIT];

	// ----------------------------------------------------------------
	// bus front end and pin synchroniser
	// ----------------------------------------------------------------
	ssp_axil_slave u_bus (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_lane_o(wr_lane),
		.wr_hit_i(wr_hit),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_hit_i(rd_hit)
	);

	// pads are asynchronous, so nothing reads them before two flops
	ssp_pin_sync u_sync (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.pin_raw_i(port_pins_all_i),
		.pin_sync_o(pin_sync)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// misaligned or unlisted addresses answer slverr, read data zero
	always @* begin
		wr_hit = 1'b0;
		if (wr_addr[1:0] == 2'b00) begin
			case (wr_idx)
				`SSP_IDX_PORT_DATA, `SSP_IDX_PORT_DIR,
				`SSP_IDX_SER0_CTRL_ONE, `SSP_IDX_SER1_CTRL_ONE,
				`SSP_IDX_SPI_CTRL_ONE, `SSP_IDX_SPI_CTRL_TWO: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// only the implemented bits are kept; the rest read back as zero.
	// a write lands at the edge that raises bvalid, so the new direction
	// steers the pins one clock later, through the pad registers
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_pin_data_ff <= `SSP_RST_PORT_DATA;
			port_pin_direction_ff <= `SSP_RST_PORT_DIR;
			serial_zero_ctrl_one_ff <= `SSP_RST_SER_CTRL;
			serial_one_ctrl_one_ff <= `SSP_RST_SER_CTRL;
			spi_ctrl_one_ff <= `SSP_RST_SPI_CTRL_ONE;
			spi_ctrl_two_pull_drive_ff <= `SSP_RST_SPI_CTRL_TWO;
		end else if (wr_ok) begin
			case (wr_idx)
				`SSP_IDX_PORT_DATA: port_pin_data_ff <= wr_data;
				`SSP_IDX_PORT_DIR: port_pin_direction_ff <= wr_data;
				`SSP_IDX_SER0_CTRL_ONE: serial_zero_ctrl_one_ff <= wr_data & 8'hC0;
				`SSP_IDX_SER1_CTRL_ONE: serial_one_ctrl_one_ff <= wr_data & 8'hC0;
				`SSP_IDX_SPI_CTRL_ONE: spi_ctrl_one_ff <= wr_data & 8'h70;
				`SSP_IDX_SPI_CTRL_TWO: spi_ctrl_two_pull_drive_ff <= wr_data & 8'h0D;
				default: port_pin_data_ff <= port_pin_data_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// peripheral claims on the pins
	// ----------------------------------------------------------------
	always @* begin
		force_in = 8'h00;
		force_out = 8'h00;
		use_fn = 8'h00;
		fn_val = 8'h00;
		spi_out_role = 8'h00;
		// serial unit zero on bits three and two
		if (!loop0) begin
			force_out[`SSP_PIN_TX0] = 1'b1;
			force_in[`SSP_PIN_RX0] = 1'b1;
			use_fn[`SSP_PIN_TX0] = 1'b1;
			fn_val[`SSP_PIN_TX0] = serial_zero_transmit_pin_i;
		end
		// serial unit one on bits one and zero
		if (!loop1) begin
			force_out[`SSP_PIN_TX1] = 1'b1;
			force_in[`SSP_PIN_RX1] = 1'b1;
			use_fn[`SSP_PIN_TX1] = 1'b1;
			fn_val[`SSP_PIN_TX1] = serial_one_transmit_pin_i;
		end
		// spi roles flip with master mode: the master drives select,
		// clock and mosi and listens on miso; a slave the other way round
		if (spi_en) begin
			if (spi_mst) begin
				spi_out_role = 8'hE0;
				force_in[`SSP_PIN_MISO] = 1'b1;
			end else begin
				spi_out_role = 8'h10;
				force_in[7:5] = 3'b111;
			end
		end
		fn_val[`SSP_PIN_SEL] = spi_select_out_i;
		fn_val[`SSP_PIN_SCK] = spi_clock_out_i;
		fn_val[`SSP_PIN_MOSI] = spi_mosi_out_i;
		fn_val[`SSP_PIN_MISO] = spi_miso_out_i;
		// spi output feeds the driver only with its direction bit set;
		// with it clear the pin stays plain port i/o
		use_fn[7:4] = spi_out_role[7:4] & port_pin_direction_ff[7:4];
	end

	// ----------------------------------------------------------------
	// driver plan, open drain and read-back
	// ----------------------------------------------------------------
	always @* begin
		nxt_drive = force_out | (port_pin_direction_ff & ~force_in);
		nxt_pin_out = (use_fn & fn_val) | (~use_fn & port_pin_data_ff);
		open_drain = {{4{spi_ctrl_one_ff[`SSP_SPI_OD_BIT]}},
			{2{serial_zero_ctrl_one_ff[`SSP_SER_OD_BIT]}},
			{2{serial_one_ctrl_one_ff[`SSP_SER_OD_BIT]}}};
		// output pins show the driver input, inputs the sampled pad
		rd_port = (port_pin_direction_ff & nxt_pin_out) | (~port_pin_direction_ff & pin_sync);
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always @* begin
		rd_hit = (rd_addr[1:0] == 2'b00);
		rd_data = 8'h00;
		case (rd_idx)
			`SSP_IDX_PORT_DATA: rd_data = rd_port;
			`SSP_IDX_PORT_DIR: rd_data = port_pin_direction_ff;
			`SSP_IDX_SER0_CTRL_ONE: rd_data = serial_zero_ctrl_one_ff;
			`SSP_IDX_SER1_CTRL_ONE: rd_data = serial_one_ctrl_one_ff;
			`SSP_IDX_SPI_CTRL_ONE: rd_data = spi_ctrl_one_ff;
			`SSP_IDX_SPI_CTRL_TWO: rd_data = spi_ctrl_two_pull_drive_ff;
			default: rd_hit = 1'b0;
		endcase
		if (!rd_hit) begin
			rd_data = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// registered pad controls
	// ----------------------------------------------------------------
	// one cycle of pipeline on every pad control keeps the outputs glitch
	// free; the cost is one clock of delay from register write to pin
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_ff <= 8'h00;
			pin_oe_n_ff <= 8'hFF; // all pins released: inputs
			pullup_ff <= 8'hFF; // pull-ups on while all are inputs
			rdrive_ff <= 8'h00; // full drive
		end else begin
			pin_out_ff <= nxt_pin_out;
			// open drain only pulls low; a one releases the pad
			pin_oe_n_ff <= ~(nxt_drive & ~(open_drain & nxt_pin_out));
			pullup_ff <= {8{spi_ctrl_two_pull_drive_ff[`SSP_PULLUP_BIT]}} & ~nxt_drive;
			rdrive_ff <= {8{spi_ctrl_two_pull_drive_ff[`SSP_RDRIVE_BIT]}};
		end
	end

	// ----------------------------------------------------------------
	// levels handed to the serial and spi units
	// ----------------------------------------------------------------
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ser_rx_ff <= 2'b11;
			spi_lvl_ff <= 4'h0;
			spi_en_ff <= 1'b0;
			spi_mst_ff <= 1'b0;
		end else begin
			ser_rx_ff <= {pin_sync[`SSP_PIN_RX1], pin_sync[`SSP_PIN_RX0]};
			spi_lvl_ff <= pin_sync[7:4];
			spi_en_ff <= spi_en;
			spi_mst_ff <= spi_mst;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign port_pins_all_o = pin_out_ff;
	assign port_pins_all_oe_n_o = pin_oe_n_ff;
	assign pullup_enable_o = pullup_ff;
	assign reduced_drive_select_o = rdrive_ff;
	assign serial_zero_receive_pin_o = ser_rx_ff[0];
	assign serial_one_receive_pin_o = ser_rx_ff[1];
	assign spi_pin_level_o = spi_lvl_ff;
	assign spi_enable_o = spi_en_ff;
	assign spi_master_o = spi_mst_ff;

endmodule

// [tb/ssp_pad_model.sv]
/* ssp_pad_model.sv - outside circuit on the eight shared pins.
   assumes: fed by the pad outputs of ssp_port; the bench sets outside levels. */
`timescale 1ns/1ps
module ssp_pad_model (
	// clock
	input clock_i,
	// pad controls, outside drivers
	input [7:0] out_i, oe_n_i, pull_i, ext_i, ext_en_i,
	// resolved level
	output [7:0] level_o
);
	reg [7:0] last_ff = 8'h00; // level of the previous cycle
	// an undriven, unpulled pin floats: show the inverse, never a stale value
	assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i) | (oe_n_i & ~ext_en_i & (pull_i | ~last_ff));
	// keep the level for the floating case
	always @(posedge clock_i) begin
		last_ff <= level_o;
	end
endmodule

// [tb/ssp_port_properties.sv]
/* ssp_port_properties.sv - bus and pad checks on ssp_port.
   assumes: bound to ssp_port; one clock domain. */
`timescale 1ns/1ps
module ssp_port_properties (
	// clock, reset, handshakes
	input clock_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
	input s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
	// payloads and pad controls
	input [1:0] s_axi_bresp_o,
	input [31:0] s_axi_rdata_o,
	input [7:0] port_pins_all_oe_n_o, pullup_enable_o, reduced_drive_select_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	// ----
	// steps
	// ----
	sequence s_wr; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o; endsequence
	sequence s_rd; s_axi_arvalid_i && s_axi_arready_o; endsequence
	sequence s_bw; s_axi_bvalid_o && !s_axi_bready_i; endsequence
	sequence s_rw; s_axi_rvalid_o && !s_axi_rready_i; endsequence
	a_b_latency: assert property (s_wr |-> ##2 s_axi_bvalid_o) else $error("b late");
	a_r_latency: assert property (s_rd |-> ##2 s_axi_rvalid_o) else $error("r late");
	a_aw_busy: assert property (s_wr |=> !s_axi_awready_o && !s_axi_wready_o) else $error("aw busy");
	a_b_hold: assert property (s_bw |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b drop");
	a_r_hold: assert property (s_rw |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r drop");
	a_rdata_top: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000) else $error("rdata");
	a_pull_out: assert property ((pullup_enable_o & ~port_pins_all_oe_n_o) == 8'h00) else $error("pull");
	a_drive_same: assert property (&reduced_drive_select_o || !(|reduced_drive_select_o)) else $error("rds");
endmodule
bind ssp_port ssp_port_properties i_ssp_port_properties (.clock_i, .arst_n_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_bresp_o, .s_axi_rdata_o,
	.port_pins_all_oe_n_o, .pullup_enable_o, .reduced_drive_select_o);

// [tb/test_ssp_port.sv]
/* test_ssp_port.sv - self-checking bench: bus tasks, random port traffic, shared pin corners.
   assumes: ssp_port, ssp_pad_model and the checker compiled first. */
`timescale 1ns/1ps
`include "ssp_map.vh"
module test_ssp_port;
	// ----
	// stimulus, wires, addresses
	// ----
	localparam [11:0] AS0 = {`SSP_IDX_SER0_CTRL_ONE, 2'b00}, AS1 = {`SSP_IDX_SER1_CTRL_ONE, 2'b00};
	localparam [11:0] AP1 = {`SSP_IDX_SPI_CTRL_ONE, 2'b00}, AP2 = {`SSP_IDX_SPI_CTRL_TWO, 2'b00};
	localparam [11:0] ADT = {`SSP_IDX_PORT_DATA, 2'b00}, ADR = {`SSP_IDX_PORT_DIR, 2'b00};
	reg clock_i = 1'b0, arst_n_i = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	reg tx0 = 1'b1, tx1 = 1'b0, sel = 1'b0, sck = 1'b0, mosi = 1'b0, miso = 1'b0;
	reg [11:0] awa = 12'h000, ara = 12'h000;
	reg [31:0] wd = 32'h0000_0000, rnd;
	reg [7:0] ext = 8'ha5, en = 8'hff, dr, dt, v;
	reg [1:0] r;
	wire awr, wrr, bv, arr, rv, rx0, rx1, spe, spm;
	wire [1:0] br, rr;
	wire [31:0] rdd;
	wire [7:0] po, oe_n, pu, reduced_drive_select, lvl;
	wire [3:0] spl;
	integer seed = 32'hf1d1_93b5, error_cnt = 0, comparisons = 0, i;
	always #10 clock_i = ~clock_i;
	ssp_port i_ssp_port (.clock_i(clock_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.port_pins_all_i(lvl), .port_pins_all_o(po), .port_pins_all_oe_n_o(oe_n), .pullup_enable_o(pu),
		.reduced_drive_select_o(reduced_drive_select), .serial_zero_transmit_pin_i(tx0), .serial_one_transmit_pin_i(tx1),
		.serial_zero_receive_pin_o(rx0), .serial_one_receive_pin_o(rx1), .spi_select_out_i(sel),
		.spi_clock_out_i(sck), .spi_mosi_out_i(mosi), .spi_miso_out_i(miso), .spi_pin_level_o(spl),
		.spi_enable_o(spe), .spi_master_o(spm));
	ssp_pad_model i_ssp_pad_model (.clock_i(clock_i), .out_i(po), .oe_n_i(oe_n), .pull_i(pu), .ext_i(ext),
		.ext_en_i(en), .level_o(lvl));
	// ----
	// checks and bus cycles
	// ----
	function [7:0] exp_rd(input [7:0] d, input [7:0] t, input [7:0] x, input [7:0] e);
		exp_rd = (d & t) | (~d & ((x & e) | ~e)); // pulled pins read high
	endfunction
	task automatic chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task automatic wrap_up;
		begin
			if (error_cnt == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// ready raised late on purpose so the answer must stand
	task automatic wr(input [11:0] a, input [7:0] d);
		integer n;
		begin
			@(posedge clock_i);
			awa <= a; wd <= {24'h00_0000, d}; awv <= 1'b1; wv <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge clock_i);
				if (awr) awv <= 1'b0;
				if (wrr) wv <= 1'b0;
				if (n == 2) bry <= 1'b1;
				if (bry && bv) begin r = br; bry <= 1'b0; n = 90; end
			end
			chk("wr wait", 8'd91, n[7:0]);
			if (n != 91) wrap_up;
		end
	endtask
	task automatic rd(input [11:0] a);
		integer n;
		begin
			@(posedge clock_i);
			ara <= a; arv <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge clock_i);
				if (arr) arv <= 1'b0;
				if (n == 2) rry <= 1'b1;
				if (rry && rv) begin v = rdd[7:0]; r = rr; rry <= 1'b0; n = 90; end
			end
			chk("rd wait", 8'd91, n[7:0]);
			if (n != 91) wrap_up;
		end
	endtask
	task automatic rchk(input [11:0] a, input [7:0] e);
		begin
			rd(a);
			chk("reg", e, v);
		end
	endtask
	task automatic settle;
		begin
			repeat (2) @(posedge clock_i);
			#1;
		end
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (4) @(posedge clock_i);
		arst_n_i <= 1'b1;
		rchk(ADR, 8'h00);
		rchk(AP2, 8'h08);
		rchk(AP1, 8'h00);
		rchk(AS0, 8'h00);
		rchk(AS1, 8'h00);
		rchk(12'h004, 8'h00);
		chk("rresp", `SSP_RESP_SLVERR, r);
		// loop bits clear: serial pins forced whatever the direction
		wr(ADR, 8'h00);
		settle;
		chk("serial dir", 8'h05, oe_n[3:0]);
		wr(ADR, 8'h0f);
		wr(ADT, 8'h00);
		settle;
		chk("serial dir", 8'h05, oe_n[3:0]);
		chk("tx pins", {tx0, tx1}, {po[3], po[1]});
		chk("rx pins", {ext[2], ext[0]}, {rx0, rx1});
		rd(ADT);
		chk("tx read", tx0, v[3]);
		wr(AS0, 8'h80);
		wr(AS1, 8'h80);
		// random directions and data, the first two all-in and all-out
		for (i = 0; i < 12; i = i + 1) begin
			rnd = $random(seed);
			dr = (i < 2) ? {8{i[0]}} : rnd[7:0];
			dt = rnd[15:8];
			ext <= rnd[23:16];
			en <= rnd[31:24];
			wr(ADR, dr);
			wr(ADT, dt);
			settle;
			chk("oe", ~dr, oe_n);
			chk("out", dt & dr, po & dr);
			chk("pull", ~dr, pu);
			rd(ADT);
			chk("data", exp_rd(dr, dt, ext, en), v);
			rchk(ADR, dr);
		end
		en <= 8'hff;
		wr(AP1, 8'h20);
		wr(AS0, 8'hc0);
		wr(ADR, 8'hff);
		wr(ADT, rnd[15:8]);
		settle;
		chk("spi od", rnd[15:12], oe_n[7:4]);
		chk("ser od", {rnd[11:10], 2'b00}, oe_n[3:0]);
		wr(AS0, 8'h80);
		{sel, sck, mosi, miso} <= rnd[3:0];
		wr(AP1, 8'h50);
		settle;
		chk("miso in", 8'h01, oe_n[4]);
		chk("spi out", {sel, sck, mosi}, po[7:5]);
		chk("spi ctl", 8'h03, {spe, spm});
		wr(ADR, 8'h0f);
		settle;
		chk("spi gpio", 8'h0f, oe_n[7:4]);
		chk("spi lvl", ext[7:4], spl);
		wr(ADR, 8'hff);
		wr(AP1, 8'h40);
		settle;
		chk("spi slave", {4'he, miso}, {oe_n[7:4], po[4]});
		wr(AP2, 8'h04);
		settle;
		chk("rds", 8'hff, reduced_drive_select);
		chk("pull off", 8'h00, pu);
		wr(12'h004, 8'h55);
		chk("bresp", `SSP_RESP_SLVERR, r);
		wrap_up;
	end
endmodule
